// ===== verilog/wavetable_synth_dac_front.sv
// Added by the designer: the APB slave port and the placing of the registers.
module wavetable_synth_dac_front (
    input  wire logic                ref_clk_in,
    input  wire logic                reset_in,
    input  wire logic                ce_in,
    input  wire synth_pkg::apb_req_t apb_in,
    output synth_pkg::apb_rsp_t      apb_out,
    output logic [16:0]              wave_addr_out,
    input  wire logic [15:0]         wave_data_in,
    output logic                     converter_on_out,
    output synth_pkg::dac_t          left_out,
    output synth_pkg::dac_t          right_out
);

    typedef struct packed {
        synth_pkg::apb_rsp_t           apb;
        logic [7:0]                    data_low;
        logic [7:0]                    data_high;
        logic [7:0]                    shadow;
        logic [7:0]                    control;
        logic [7:0]                    select;
        logic [7:0]                    fine_low;
        logic [7:0]                    oct_high;
        logic [7:0]                    start_low;
        logic [3:0]                    start_high;
        logic [7:0]                    loop_low;
        logic [7:0]                    loop_high;
        logic [7:0]                    env;
        logic [7:0]                    left_low;
        logic [7:0]                    right_low;
        synth_pkg::voice_t [15:0]      voice;
        logic [7:0]                    slot;
        logic [16:0]                   wave_addr;
        logic                          wave_odd;
        logic signed [20:0]            acc_left;
        logic signed [20:0]            acc_right;
        synth_pkg::dac_t               left;
        synth_pkg::dac_t               right;
    } state_t;

    state_t st;
    state_t next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'h0) && (addr <= synth_pkg::OFS_ACTIVE);
    endfunction : mapped

    // octave codes C..F freeze the voice
    function automatic logic [22:0] step_of(input logic [11:0] fine,
                                            input logic [3:0]  octave);
        if (octave >= synth_pkg::OCTAVE_STOP) begin
            return 23'h000000;
        end
        return {11'h000, fine} << octave;
    endfunction : step_of

    // level = sample * (128 - low six) / 128, halved per high-four step
    function automatic logic signed [15:0] scale(input logic signed [15:0] s,
                                                 input logic [9:0]         v);
        logic signed [24:0] prod;
        prod = s * $signed({1'b0, synth_pkg::LOUD_FULL - {2'h0, v[5:0]}});
        prod = prod >>> 7;
        prod = prod >>> v[9:6];
        return prod[15:0];
    endfunction : scale

    function automatic logic [15:0] sat16(input logic signed [20:0] a);
        if (a > 21'sd32767) begin
            return 16'h7FFF;
        end
        if (a < -21'sd32768) begin
            return 16'h8000;
        end
        return a[15:0];
    endfunction : sat16

    function automatic logic [16:0] addr_of(input synth_pkg::voice_t v);
        logic [16:0] base;
        logic [15:0] nib;
        base = {v.start, 5'h00};
        nib  = {v.pos, 1'b0} + {1'b0, v.pos};
        if (v.wide) begin
            return base + {2'h0, nib[15:1]};
        end
        return base + {2'h0, v.pos};
    endfunction : addr_of

    function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] addr);
        logic [15:0] act;
        for (int i = 0; i < synth_pkg::VOICES; i++) begin
            act[i] = s.voice[i].active;
        end
        case (addr)
            synth_pkg::OFS_DATA_LOW:   return {24'h000000, s.data_low};
            synth_pkg::OFS_DATA_HIGH:  return {24'h000000, s.data_high};
            synth_pkg::OFS_CONTROL:    return {24'h000000, s.control & synth_pkg::CTRL_MASK};
            synth_pkg::OFS_SELECT:     return {24'h000000, s.select};
            synth_pkg::OFS_FINE_LOW:   return {24'h000000, s.fine_low};
            synth_pkg::OFS_OCT_HIGH:   return {24'h000000, s.oct_high};
            synth_pkg::OFS_START_LOW:  return {24'h000000, s.start_low};
            synth_pkg::OFS_START_HIGH: return {28'h0000000, s.start_high};
            synth_pkg::OFS_LOOP_LOW:   return {24'h000000, s.loop_low};
            synth_pkg::OFS_LOOP_HIGH:  return {24'h000000, s.loop_high};
            synth_pkg::OFS_ENV:        return {24'h000000, s.env};
            synth_pkg::OFS_LEFT_LOW:   return {24'h000000, s.left_low};
            synth_pkg::OFS_RIGHT_LOW:  return {24'h000000, s.right_low};
            synth_pkg::OFS_ACTIVE:     return {16'h0000, act};
            default:                   return 32'h00000000;
        endcase
    endfunction : read_mux

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        synth_pkg::voice_t  cur;
        logic [3:0]         vix;
        logic               wr;
        logic [7:0]         wd;
        logic [11:0]        s12;
        logic signed [15:0] s16;
        logic               at_end;
        logic [31:0]        acc;
        next_st = st;
        cur     = st.voice[st.slot[4:1]];
        vix     = st.slot[4:1];
        wd      = apb_in.pwdata[7:0];
        s12     = 12'h000;
        s16     = 16'sh0000;
        at_end  = 1'b0;
        acc     = 32'h00000000;
        wr      = apb_in.psel && apb_in.penable && st.apb.pready && apb_in.pwrite;

        next_st.left.load  = 1'b0;
        next_st.right.load = 1'b0;
        next_st.apb.pready = 1'b0;

        // zero wait state: answer is prepared during the setup cycle
        if (apb_in.psel && !apb_in.penable) begin
            next_st.apb.pready  = 1'b1;
            next_st.apb.pslverr = !mapped(apb_in.paddr);
            next_st.apb.prdata  = apb_in.pwrite ? 32'h00000000 : read_mux(st, apb_in.paddr);
        end

        // ---------------- engine: two slots per voice, then publish
        next_st.slot = st.slot + 8'h01;
        if (st.slot < synth_pkg::SLOT_PUBLISH) begin
            if (!st.slot[0]) begin
                next_st.wave_addr = addr_of(cur);
                next_st.wave_odd  = cur.wide && cur.pos[0];
            end else if (cur.active) begin
                if (cur.wide) begin
                    s12    = st.wave_odd ? {wave_data_in[3:0], wave_data_in[15:8]}
                                         : {wave_data_in[7:0], wave_data_in[15:12]};
                    at_end = s12[11:4] == synth_pkg::END_CODE;
                    s16    = $signed({s12, 4'h0});
                end else begin
                    at_end = wave_data_in[7:0] == synth_pkg::END_CODE;
                    s16    = $signed({wave_data_in[7:0], 8'h00});
                end
                if (at_end) begin
                    // carry out of the top bit drops, so offsets wrap backwards
                    cur.pos = cur.pos + cur.loop;
                end else begin
                    acc = {cur.pos, cur.frac} + {9'h000, step_of(cur.fine, cur.octave)};
                    {cur.pos, cur.frac} = acc;
                    next_st.acc_left  = st.acc_left + 21'(scale(s16, cur.left));
                    next_st.acc_right = st.acc_right + 21'(scale(s16, cur.right));
                end
                next_st.voice[vix] = cur;
            end
        end else if (st.slot == synth_pkg::SLOT_PUBLISH) begin
            if (st.control[synth_pkg::CTRL_LEFT_BIT]) begin
                next_st.left.data = sat16(st.acc_left);
                next_st.left.load = 1'b1;
            end
            if (st.control[synth_pkg::CTRL_RIGHT_BIT]) begin
                next_st.right.data = sat16(st.acc_right);
                next_st.right.load = 1'b1;
            end
            next_st.acc_left  = 21'sh00000;
            next_st.acc_right = 21'sh00000;
        end

        // ---------------- register writes
        if (wr) begin
            if (hit(apb_in.paddr, synth_pkg::OFS_DATA_LOW)) begin
                next_st.shadow = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_DATA_HIGH)) begin
                next_st.data_high = wd;
                next_st.data_low  = st.shadow;
                if (!st.control[synth_pkg::CTRL_LEFT_BIT]) begin
                    next_st.left.data = {wd, st.shadow};
                    next_st.left.load = 1'b1;
                end
                if (!st.control[synth_pkg::CTRL_RIGHT_BIT]) begin
                    next_st.right.data = {wd, st.shadow};
                    next_st.right.load = 1'b1;
                end
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_CONTROL)) begin
                next_st.control = wd & synth_pkg::CTRL_MASK;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_FINE_LOW)) begin
                next_st.fine_low = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_OCT_HIGH)) begin
                next_st.oct_high = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_START_LOW)) begin
                next_st.start_low = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_START_HIGH)) begin
                next_st.start_high = wd[3:0];
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_LOOP_LOW)) begin
                next_st.loop_low = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_LOOP_HIGH)) begin
                next_st.loop_high = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_ENV)) begin
                next_st.env = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_LEFT_LOW)) begin
                next_st.left_low = wd;
            end
            if (hit(apb_in.paddr, synth_pkg::OFS_RIGHT_LOW)) begin
                next_st.right_low = wd;
            end
            // applied after the engine so a restart beats a same-cycle step
            if (hit(apb_in.paddr, synth_pkg::OFS_SELECT)) begin
                next_st.select = wd;
                cur = next_st.voice[wd[3:0]];
                if (wd[7:6] == synth_pkg::UPD_ALL || wd[7:6] == synth_pkg::UPD_PITCH) begin
                    cur.fine   = {st.oct_high[3:0], st.fine_low};
                    cur.octave = st.oct_high[7:4];
                end
                if (wd[7:6] == synth_pkg::UPD_ALL || wd[7:6] == synth_pkg::UPD_LOUD) begin
                    cur.left  = {st.env[5:4], st.left_low};
                    cur.right = {st.env[1:0], st.right_low};
                end
                if (wd[7:6] == synth_pkg::UPD_ALL) begin
                    cur.start  = {st.start_high, st.start_low};
                    cur.loop   = {st.loop_high[6:0], st.loop_low};
                    cur.wide   = st.loop_high[synth_pkg::WIDTH_SEL_BIT];
                    cur.active = 1'b1;
                    cur.pos    = 15'h0000;
                    cur.frac   = 17'h00000;
                end
                next_st.voice[wd[3:0]] = cur;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st         <= '0;
            st.control <= synth_pkg::CTRL_RESET;
            st.select  <= synth_pkg::SELECT_RESET;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign apb_out          = st.apb;
    assign wave_addr_out    = st.wave_addr;
    assign converter_on_out = st.control[synth_pkg::CTRL_ON_BIT];
    assign left_out         = st.left;
    assign right_out        = st.right;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence sw_high_write;
        ce_in && apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite
            && apb_in.paddr == synth_pkg::OFS_DATA_HIGH;
    endsequence

    sequence frame_publish;
        ce_in && st.slot == synth_pkg::SLOT_PUBLISH;
    endsequence

    ctrl_reserved_a: assert property (ce_in && apb_in.psel && !apb_in.penable
        && !apb_in.pwrite && apb_in.paddr == synth_pkg::OFS_CONTROL
        |=> apb_out.pready && apb_out.prdata[6:2] == 5'h00)
        else $error("control reserved bits not zero");

    shadow_hidden_a: assert property (ce_in && apb_in.psel && apb_in.penable
        && apb_out.pready && apb_in.pwrite && apb_in.paddr == synth_pkg::OFS_DATA_LOW
        |=> st.data_low == $past(st.data_low) && st.shadow == $past(apb_in.pwdata[7:0]))
        else $error("low byte changed on low write");

    pair_copy_a: assert property (sw_high_write |=> st.data_low == $past(st.shadow))
        else $error("shadow not copied on high write");

    left_load_a: assert property (sw_high_write ##0 !st.control[1]
        |=> left_out.load && left_out.data == {$past(apb_in.pwdata[7:0]), $past(st.shadow)})
        else $error("left software conversion not started");

    right_load_a: assert property (sw_high_write ##0 !st.control[0]
        |=> right_out.load && right_out.data[15:8] == $past(apb_in.pwdata[7:0]))
        else $error("right software conversion not started");

    engine_left_a: assert property (frame_publish ##0 st.control[1]
        |=> left_out.load && left_out.data == sat16($past(st.acc_left)))
        else $error("left engine sum not published");

    engine_right_a: assert property (frame_publish ##0 st.control[0]
        |=> right_out.load && right_out.data == sat16($past(st.acc_right)))
        else $error("right engine sum not published");

    // own disable: the default one would mask every attempt of this check
    reset_off_a: assert property (disable iff (1'b0) reset_in |=> !converter_on_out [*2])
        else $error("converter on after reset");

    voice_start_a: assert property (ce_in && apb_in.psel && apb_in.penable
        && apb_out.pready && apb_in.pwrite && apb_in.paddr == synth_pkg::OFS_SELECT
        && apb_in.pwdata[7:6] == synth_pkg::UPD_ALL
        |=> st.voice[$past(apb_in.pwdata[3:0])].active
            && st.voice[$past(apb_in.pwdata[3:0])].pos == 15'h0000)
        else $error("voice not restarted");

    // unity pitch: one sample per frame, the fraction left alone
    unity_step_a: assert property (ce_in && st.slot < synth_pkg::SLOT_PUBLISH
        && st.slot[0] && !(apb_in.penable && apb_in.pwrite) && st.voice[st.slot[4:1]].active
        && st.voice[st.slot[4:1]].fine == 12'h800 && st.voice[st.slot[4:1]].octave == 4'h6
        |=> st.voice[$past(st.slot[4:1])].frac == $past(st.voice[st.slot[4:1]].frac)
            && (st.voice[$past(st.slot[4:1])].pos
                == $past(st.voice[st.slot[4:1]].pos) + 15'h0001
            || st.voice[$past(st.slot[4:1])].pos
                == $past(st.voice[st.slot[4:1]].pos + st.voice[st.slot[4:1]].loop)))
        else $error("unity pitch step wrong");

    // a low enable holds every bit, so load pulses stretch with it
    state_freeze_a: assert property (!ce_in |=> $stable(st))
        else $error("state moved while enable low");

endmodule : wavetable_synth_dac_front

// ===== inc/synth_pkg.sv
package synth_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA_LOW   = 8'h00;
    localparam logic [7:0] OFS_DATA_HIGH  = 8'h04;
    localparam logic [7:0] OFS_CONTROL    = 8'h08;
    localparam logic [7:0] OFS_SELECT     = 8'h0C;
    localparam logic [7:0] OFS_FINE_LOW   = 8'h10;
    localparam logic [7:0] OFS_OCT_HIGH   = 8'h14;
    localparam logic [7:0] OFS_START_LOW  = 8'h18;
    localparam logic [7:0] OFS_START_HIGH = 8'h1C;
    localparam logic [7:0] OFS_LOOP_LOW   = 8'h20;
    localparam logic [7:0] OFS_LOOP_HIGH  = 8'h24;
    localparam logic [7:0] OFS_ENV        = 8'h28;
    localparam logic [7:0] OFS_LEFT_LOW   = 8'h2C;
    localparam logic [7:0] OFS_RIGHT_LOW  = 8'h30;
    localparam logic [7:0] OFS_ACTIVE     = 8'h34;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_ON_BIT    = 7;
    localparam int         CTRL_LEFT_BIT  = 1;
    localparam int         CTRL_RIGHT_BIT = 0;
    localparam logic [7:0] CTRL_MASK      = 8'h83;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] SELECT_RESET   = 8'h00;
    localparam int         WIDTH_SEL_BIT  = 7;
    localparam logic [1:0] UPD_ALL        = 2'h0;
    localparam logic [1:0] UPD_PITCH      = 2'h1;
    localparam logic [1:0] UPD_LOUD       = 2'h2;

    // ------------------------------------------------------------
    // engine constants
    // ------------------------------------------------------------
    localparam int         VOICES        = 16;
    localparam logic [7:0] END_CODE      = 8'h80;
    localparam logic [3:0] OCTAVE_STOP   = 4'hC;
    localparam int         FRAC_W        = 17;
    localparam int         POS_W         = 15;
    localparam logic [7:0] SLOT_PUBLISH  = 8'h20;
    localparam logic [7:0] LOUD_FULL     = 8'h80;
    localparam logic [22:0] STEP_UNITY   = 23'h020000;

    typedef struct packed {
        logic [11:0] fine;
        logic [3:0]  octave;
        logic [11:0] start;
        logic [14:0] loop;
        logic        wide;
        logic [9:0]  left;
        logic [9:0]  right;
        logic        active;
        logic [14:0] pos;
        logic [16:0] frac;
    } voice_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic        load;
        logic [15:0] data;
    } dac_t;

endpackage : synth_pkg

// ===== tb/dac_mem_model.sv
module dac_mem_model (
    input  wire logic            ref_clk_in,
    input  wire logic [16:0]     wave_addr_in,
    output logic [15:0]          wave_data_out,
    input  wire synth_pkg::dac_t left_in,
    input  wire synth_pkg::dac_t right_in,
    output int                   left_loads_out,
    output int                   right_loads_out,
    output logic [15:0]          left_val_out,
    output logic [15:0]          right_val_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // sample memory: 11h..14h then end codes
    // ----------------------------------------
    function automatic logic [7:0] byte_at(input logic [16:0] a);
        return (a < 17'h00004) ? a[7:0] + 8'h11 : synth_pkg::END_CODE;
    endfunction : byte_at

    assign wave_data_out = {byte_at(wave_addr_in + 17'h00001), byte_at(wave_addr_in)};

    // ----------------------------------------
    // converter: counts conversions per side
    // ----------------------------------------
    initial begin
        left_loads_out = 0;
        right_loads_out = 0;
        left_val_out = 16'h0000;
        right_val_out = 16'h0000;
    end
    always @(posedge ref_clk_in) begin
        if (left_in.load === 1'b1) begin
            left_loads_out <= left_loads_out + 1;
            left_val_out <= left_in.data;
        end
        if (right_in.load === 1'b1) begin
            right_loads_out <= right_loads_out + 1;
            right_val_out <= right_in.data;
        end
    end
endmodule : dac_mem_model

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 16;
    logic                clk;
    logic                rst;
    logic                ce;
    synth_pkg::apb_req_t req;
    synth_pkg::apb_rsp_t rsp;
    synth_pkg::dac_t     left;
    synth_pkg::dac_t     right;
    logic [16:0]         waddr;
    logic [15:0]         wdata;
    logic                on;
    int                  ll, rl, cycles, bad_count, tests_run;
    logic [15:0]         lv, rv, v1;
    logic [15:0]         seq [12];
    logic [15:0]         cfg [10];

    wavetable_synth_dac_front uut (.ref_clk_in(clk), .reset_in(rst), .ce_in(ce),
        .apb_in(req), .apb_out(rsp), .wave_addr_out(waddr), .wave_data_in(wdata),
        .converter_on_out(on), .left_out(left), .right_out(right));
    dac_mem_model far (.ref_clk_in(clk), .wave_addr_in(waddr), .wave_data_out(wdata),
        .left_in(left), .right_in(right), .left_loads_out(ll), .right_loads_out(rl),
        .left_val_out(lv), .right_val_out(rv));

    always #2.5 clk = ~clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // a hang in any wait ends up here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge; answer taken at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        xfer(1'b1, a, d, rd, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        xfer(1'b0, a, 8'h00, rd, e);
        chk(rd, exp);
    endtask : rd_chk

    task automatic wait_loads(input int n);
        int t, c;
        t = rl + n;
        c = 0;
        while (rl < t && c < 400 * n) begin
            @(posedge clk);
            c++;
        end
        @(negedge clk);
        chk(32'(rl >= t), 32'h00000001);
    endtask : wait_loads

    // software channels convert {hi, shadow}; engine channels must not take it
    task automatic dac_write(input logic [7:0] hi, input logic [1:0] sel, input logic [15:0] v);
        int l0, r0;
        l0 = ll;
        r0 = rl;
        wr(synth_pkg::OFS_DATA_HIGH, hi);
        repeat (3) @(posedge clk);
        @(negedge clk);
        if (sel[1] == 1'b0) chk(32'(ll - l0), 32'h00000001);
        chk(32'(lv === v), {31'h0, ~sel[1]});
        if (sel[0] == 1'b0) chk(32'(rl - r0), 32'h00000001);
        chk(32'(rv === v), {31'h0, ~sel[0]});
    endtask : dac_write

    initial begin : main
        logic [31:0] d;
        logic        e;
        int          nd;
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        cycles = 0;
        bad_count = 0;
        tests_run = 0;
        cfg = '{16'h1000, 16'h14C8, 16'h1800, 16'h1C00, 16'h20FC, 16'h247F,
                16'h2800, 16'h2C00, 16'h3000, 16'h0C00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(synth_pkg::OFS_CONTROL, 32'h00000000);
        rd_chk(synth_pkg::OFS_SELECT, 32'h00000000);
        wr(synth_pkg::OFS_CONTROL, 8'hFF);
        rd_chk(synth_pkg::OFS_CONTROL, 32'h00000083);
        chk({31'h0, on}, 32'h00000001);
        xfer(1'b0, 8'h38, 8'h00, d, e);
        chk({31'h0, e}, 32'h00000001);
        wr(synth_pkg::OFS_CONTROL, 8'h00);
        @(negedge clk);
        chk({31'h0, on}, 32'h00000000);
        wr(synth_pkg::OFS_CONTROL, 8'h80);
        @(negedge clk);
        chk({31'h0, on}, 32'h00000001);
        repeat (SETTLE) @(posedge clk);
        wr(synth_pkg::OFS_DATA_LOW, 8'h34);
        dac_write(8'h12, 2'b00, 16'h1234);
        rd_chk(synth_pkg::OFS_DATA_LOW, 32'h00000034);
        wr(synth_pkg::OFS_DATA_LOW, 8'h56);
        rd_chk(synth_pkg::OFS_DATA_LOW, 32'h00000034);
        wr(synth_pkg::OFS_CONTROL, 8'h82);
        dac_write(8'h78, 2'b10, 16'h7856);
        rd_chk(synth_pkg::OFS_DATA_LOW, 32'h00000056);
        rd_chk(synth_pkg::OFS_DATA_HIGH, 32'h00000078);
        wr(synth_pkg::OFS_CONTROL, 8'h81);
        dac_write(8'h9A, 2'b01, 16'h9A56);
        // voice 0: frozen octave, 8-bit samples, loop back over four samples
        wr(synth_pkg::OFS_CONTROL, 8'h83);
        foreach (cfg[i]) wr(cfg[i][15:8], cfg[i][7:0]);
        wait_loads(3);
        v1 = rv;
        chk(32'(v1 !== 16'h0000), 32'h00000001);
        chk({16'h0, lv}, {16'h0, v1});
        wait_loads(1);
        chk({16'h0, rv}, {16'h0, v1});
        // enable low: engine frozen, no right conversion may start
        @(posedge clk);
        nd = rl;
        ce <= 1'b0;
        repeat (300) @(posedge clk);
        chk(32'(rl - nd), 32'h00000000);
        ce <= 1'b1;
        wr(synth_pkg::OFS_SELECT, 8'h01);
        wait_loads(3);
        chk({16'h0, rv}, {15'h0, v1, 1'b0});
        rd_chk(synth_pkg::OFS_ACTIVE, 32'h00000003);
        wr(synth_pkg::OFS_LEFT_LOW, 8'hFF);
        wr(synth_pkg::OFS_ENV, 8'h30);
        wr(synth_pkg::OFS_SELECT, 8'h80);
        wr(synth_pkg::OFS_SELECT, 8'h81);
        wait_loads(3);
        chk({16'h0, lv}, 32'h00000000);
        chk({16'h0, rv}, {15'h0, v1, 1'b0});
        wr(synth_pkg::OFS_OCT_HIGH, 8'h68);
        wr(synth_pkg::OFS_SELECT, 8'h40);
        wait_loads(2);
        foreach (seq[k]) begin
            wait_loads(1);
            seq[k] = rv;
        end
        for (int k = 0; k < 7; k++) chk({16'h0, seq[k]}, {16'h0, seq[k + 5]});
        nd = 0;
        for (int k = 0; k < 5; k++) nd += int'(seq[k] !== seq[k + 1]);
        chk(32'(nd >= 3), 32'h00000001);
        // voice 0 restarted frozen in 12-bit format: 111h beside voice 1's 8-bit 11h
        wr(synth_pkg::OFS_OCT_HIGH, 8'hC8);
        wr(synth_pkg::OFS_LOOP_HIGH, 8'hFF);
        wr(synth_pkg::OFS_SELECT, 8'h00);
        wait_loads(3);
        chk({16'h0, rv}, 32'h00002210);
        // reset in mid-run with the converter on
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, on}, 32'h00000000);
        rd_chk(synth_pkg::OFS_ACTIVE, 32'h00000000);
        rd_chk(synth_pkg::OFS_CONTROL, 32'h00000000);
        end_of_test();
    end
endmodule : tb
